/* File: common/sysevt_pkg.sv */
package sysevt_pkg;

	// ***************************************************************
	// Device configuration index space
	// ***************************************************************
	localparam logic [7:0]  OFS_CACHE_CFG   = 8'h14;
	localparam logic [7:0]  OFS_MISC_EN     = 8'h90;
	localparam logic [7:0]  OFS_CARD_KBD_EN = 8'h91;
	localparam logic [7:0]  OFS_BATAC_EN    = 8'h93;
	localparam logic [7:0]  OFS_BATAC_STAT  = 8'h97;
	localparam logic [7:0]  OFS_TRAP_EN_A   = 8'h99;
	localparam logic [7:0]  OFS_TRAP_EN_B   = 8'h9A;
	localparam logic [7:0]  OFS_EVT_CTRL    = 8'h9D;
	localparam logic [7:0]  REG_RESET       = 8'h00;
	localparam int          CACHE_WT_BIT    = 0;
	localparam int          MISC_LO         = 2;
	localparam int          MISC_HI         = 6;
	localparam int          CTRL_SMI_EN     = 0;
	localparam int          CTRL_NMI_ROUTE  = 1;
	localparam logic [7:0]  CTRL_WMASK      = 8'h03;
	localparam logic [7:0]  CARD_KBD_WMASK  = 8'h0F;
	localparam logic [7:0]  TRAP_A_WMASK    = 8'h1F;
	localparam logic [7:0]  TRAP_B_WMASK    = 8'h7F;
	localparam int          PORT70_GATE_BIT = 7;
	localparam logic        NMI_GATE_RESET  = 1'b1;

	// ***************************************************************
	// Event sources
	// ***************************************************************
	localparam int          NUM_FALL   = 5;
	localparam int          NUM_BATAC  = 4;
	localparam int          NUM_CK     = 4;
	localparam int          NUM_PINS   = NUM_FALL + NUM_BATAC + NUM_CK;
	localparam int          NUM_TRAP_A = 5;
	localparam int          NUM_TRAP_B = 7;
	localparam int          NUM_TRAP   = NUM_TRAP_A + NUM_TRAP_B;
	localparam logic        PIN_IDLE   = 1'b1;
	localparam logic [1:0]  SETTLE_CYC = 2'h3;
	localparam logic [15:0] TRAP_MASK  = 16'hFFF8;
	localparam logic [15:0] TRAP_BASE [NUM_TRAP] = '{
		16'h01F0, 16'h0170, 16'h03F0, 16'h0370, 16'h03F8, 16'h02F8,
		16'h0378, 16'h0278, 16'h03E0, 16'h0060, 16'h03B0, 16'h03C0};
	localparam logic [15:0] SS_RESTART_ADDR = 16'hFF00;
	localparam logic [7:0]  SS_RESTART_VAL  = 8'hFF;

	// ***************************************************************
	// Controller register port
	// ***************************************************************
	localparam logic [7:0]  H_ADDR     = 8'h00;
	localparam logic [7:0]  H_WDATA    = 8'h04;
	localparam logic [7:0]  H_CMD      = 8'h08;
	localparam logic [7:0]  H_CFG_DATA = 8'h0C;
	localparam logic [7:0]  H_STAT     = 8'h10;
	localparam logic [7:0]  H_MASK     = 8'h14;
	localparam logic [7:0]  H_LEVEL    = 8'h18;
	localparam int          PB_CFG_WR  = 0;
	localparam int          PB_CFG_RD  = 1;
	localparam int          PB_P70     = 2;
	localparam int          PB_SS_WR   = 3;
	localparam int          PB_IO      = 4;
	localparam int          PB_SMI_ACK = 5;
	localparam int          PB_NMI_ACK = 6;
	localparam int          PB_RSM     = 7;
	localparam int          ST_SMI     = 0;
	localparam int          ST_NMI     = 1;
	localparam int          ST_RESTART = 2;

endpackage

/* File: common/sysevt_if.sv */
`timescale 1ns/1ps
interface sysevt_if;
	logic [7:0]  cfg_addr;
	logic [7:0]  cfg_wdata;
	logic        cfg_wr;
	logic        cfg_rd;
	logic [7:0]  cfg_rdata;
	logic        port70_wr;
	logic [7:0]  port70_wdata;
	logic        io_valid;
	logic [15:0] io_addr;
	logic        ss_wr;
	logic [15:0] ss_addr;
	logic [7:0]  ss_wdata;
	logic        rsm;
	logic        smi_ack;
	logic        nmi_ack;
	logic        smi;
	logic        nmi;
	logic        io_restart;

	modport dev (
		input  cfg_addr, cfg_wdata, cfg_wr, cfg_rd, port70_wr, port70_wdata, io_valid, io_addr,
		input  ss_wr, ss_addr, ss_wdata, rsm, smi_ack, nmi_ack,
		output cfg_rdata, smi, nmi, io_restart
	);
	modport cpu (
		output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, port70_wr, port70_wdata, io_valid, io_addr,
		output ss_wr, ss_addr, ss_wdata, rsm, smi_ack, nmi_ack,
		input  cfg_rdata, smi, nmi, io_restart
	);
endinterface

/* File: hw/sysevt_device.sv */
`timescale 1ns/1ps
module sysevt_device
	import sysevt_pkg::*;
(
	input  wire logic                mclk_i,
	input  wire logic                srst_i,
	sysevt_if.dev                    bus,
	input  wire logic                suspend_resume_pin_i,
	input  wire logic [3:0]          misc_fall_pin_i,
	input  wire logic [2:0]          batlow_pin_i,
	input  wire logic                acpresent_pin_i,
	input  wire logic [NUM_CK-1:0]   card_kbd_pin_i,
	output logic                     cache_write_through_o
);

	// ***************************************************************
	// Pin synchronizers and edge detectors
	// ***************************************************************
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] sync1;
	logic [NUM_PINS-1:0] sync2;
	logic [NUM_PINS-1:0] prev;
	logic [NUM_PINS-1:0] rise;
	logic [NUM_PINS-1:0] fall;
	logic [1:0]          settle;
	logic [1:0]          next_settle;
	logic                armed;

	assign pin_raw = {card_kbd_pin_i, acpresent_pin_i, batlow_pin_i, misc_fall_pin_i, suspend_resume_pin_i};
	assign armed   = (settle == SETTLE_CYC);

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
			always_ff @(posedge mclk_i) begin
				if (srst_i) begin
					sync1[gp] <= PIN_IDLE;
					sync2[gp] <= PIN_IDLE;
					prev[gp]  <= PIN_IDLE;
				end else begin
					sync1[gp] <= pin_raw[gp];
					sync2[gp] <= sync1[gp];
					prev[gp]  <= sync2[gp];
				end
			end
			// Edges are ignored until the chain has filled after reset.
			assign rise[gp] = armed & sync2[gp] & ~prev[gp];
			assign fall[gp] = armed & ~sync2[gp] & prev[gp];
		end
	endgenerate

	always_comb begin
		next_settle = armed ? settle : settle + 2'h1;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			settle <= 2'h0;
		end else begin
			settle <= next_settle;
		end
	end

	// ***************************************************************
	// Configuration registers
	// ***************************************************************
	logic [7:0] cache_cfg;
	logic [7:0] misc_en;
	logic [7:0] card_kbd_en;
	logic [7:0] batac_en;
	logic [7:0] batac_stat;
	logic [7:0] trap_en_a;
	logic [7:0] trap_en_b;
	logic [7:0] evt_ctrl;
	logic [7:0] rdata;
	logic       nmi_gate_off;
	logic [7:0] next_cache_cfg;
	logic [7:0] next_misc_en;
	logic [7:0] next_card_kbd_en;
	logic [7:0] next_batac_en;
	logic [7:0] next_batac_stat;
	logic [7:0] next_trap_en_a;
	logic [7:0] next_trap_en_b;
	logic [7:0] next_evt_ctrl;
	logic [7:0] next_rdata;
	logic       next_nmi_gate_off;
	logic [7:0] batac_hit;
	logic       wr_misc;

	assign wr_misc = bus.cfg_wr && (bus.cfg_addr == OFS_MISC_EN);

	genvar gb;
	generate
		for (gb = 0; gb < NUM_BATAC; gb++) begin : g_batac
			assign batac_hit[2*gb+1] = rise[NUM_FALL+gb] & batac_en[2*gb+1];
			assign batac_hit[2*gb]   = fall[NUM_FALL+gb] & batac_en[2*gb];
		end
	endgenerate

	always_comb begin
		next_cache_cfg    = cache_cfg;
		next_misc_en      = misc_en;
		next_card_kbd_en  = card_kbd_en;
		next_batac_en     = batac_en;
		next_trap_en_a    = trap_en_a;
		next_trap_en_b    = trap_en_b;
		next_evt_ctrl     = evt_ctrl;
		next_nmi_gate_off = nmi_gate_off;
		next_batac_stat   = batac_stat | batac_hit;
		if (bus.cfg_wr) begin
			unique case (bus.cfg_addr)
				OFS_CACHE_CFG:   next_cache_cfg   = bus.cfg_wdata;
				OFS_MISC_EN:     next_misc_en     = bus.cfg_wdata;
				OFS_CARD_KBD_EN: next_card_kbd_en = bus.cfg_wdata & CARD_KBD_WMASK;
				OFS_BATAC_EN:    next_batac_en    = bus.cfg_wdata;
				// Write one to clear; a new edge in the same cycle still sets.
				OFS_BATAC_STAT:  next_batac_stat  = (batac_stat & ~bus.cfg_wdata) | batac_hit;
				OFS_TRAP_EN_A:   next_trap_en_a   = bus.cfg_wdata & TRAP_A_WMASK;
				OFS_TRAP_EN_B:   next_trap_en_b   = bus.cfg_wdata & TRAP_B_WMASK;
				OFS_EVT_CTRL:    next_evt_ctrl    = bus.cfg_wdata & CTRL_WMASK;
				default: ;
			endcase
		end
		if (bus.port70_wr) begin
			next_nmi_gate_off = bus.port70_wdata[PORT70_GATE_BIT];
		end
		next_rdata = 8'h00;
		if (bus.cfg_rd) begin
			unique case (bus.cfg_addr)
				OFS_CACHE_CFG:   next_rdata = cache_cfg;
				OFS_MISC_EN:     next_rdata = misc_en;
				OFS_CARD_KBD_EN: next_rdata = card_kbd_en;
				OFS_BATAC_EN:    next_rdata = batac_en;
				OFS_BATAC_STAT:  next_rdata = batac_stat;
				OFS_TRAP_EN_A:   next_rdata = trap_en_a;
				OFS_TRAP_EN_B:   next_rdata = trap_en_b;
				OFS_EVT_CTRL:    next_rdata = evt_ctrl;
				default:         next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cache_cfg    <= REG_RESET;
			misc_en      <= REG_RESET;
			card_kbd_en  <= REG_RESET;
			batac_en     <= REG_RESET;
			batac_stat   <= REG_RESET;
			trap_en_a    <= REG_RESET;
			trap_en_b    <= REG_RESET;
			evt_ctrl     <= REG_RESET;
			rdata        <= REG_RESET;
			nmi_gate_off <= NMI_GATE_RESET;
		end else begin
			cache_cfg    <= next_cache_cfg;
			misc_en      <= next_misc_en;
			card_kbd_en  <= next_card_kbd_en;
			batac_en     <= next_batac_en;
			batac_stat   <= next_batac_stat;
			trap_en_a    <= next_trap_en_a;
			trap_en_b    <= next_trap_en_b;
			evt_ctrl     <= next_evt_ctrl;
			rdata        <= next_rdata;
			nmi_gate_off <= next_nmi_gate_off;
		end
	end

	assign bus.cfg_rdata          = rdata;
	assign cache_write_through_o  = cache_cfg[CACHE_WT_BIT];

	// ***************************************************************
	// Event collection and delivery
	// ***************************************************************
	logic [NUM_TRAP-1:0] trap_hit;
	logic [NUM_TRAP-1:0] trap_en;
	logic                misc_evt;
	logic                misc_now;
	logic                ck_evt;
	logic                pin_evt;
	logic                route_nmi;
	logic                smi_pend;
	logic                nmi_pend;
	logic                restart_armed;
	logic                io_restart;
	logic                next_smi_pend;
	logic                next_nmi_pend;
	logic                next_restart_armed;
	logic                next_io_restart;

	assign trap_en = {trap_en_b[NUM_TRAP_B-1:0], trap_en_a[NUM_TRAP_A-1:0]};

	genvar gt;
	generate
		for (gt = 0; gt < NUM_TRAP; gt++) begin : g_trap
			assign trap_hit[gt] = bus.io_valid & trap_en[gt] &
				((bus.io_addr & TRAP_MASK) == TRAP_BASE[gt]);
		end
	endgenerate

	assign misc_evt  = |(fall[NUM_FALL-1:0] & misc_en[MISC_HI:MISC_LO]);
	// A source enabled while its pin already sits low fires at once.
	assign misc_now  = wr_misc &
		|(bus.cfg_wdata[MISC_HI:MISC_LO] & ~misc_en[MISC_HI:MISC_LO] & ~sync2[NUM_FALL-1:0]);
	assign ck_evt    = |(rise[NUM_PINS-1:NUM_FALL+NUM_BATAC] & card_kbd_en[NUM_CK-1:0]);
	assign pin_evt   = misc_evt | misc_now | (|batac_hit) | ck_evt;
	assign route_nmi = evt_ctrl[CTRL_NMI_ROUTE];

	always_comb begin
		next_smi_pend = ((|trap_hit) | (pin_evt & ~route_nmi)) | (smi_pend & ~bus.smi_ack);
		next_nmi_pend = (pin_evt & route_nmi) | (nmi_pend & ~bus.nmi_ack);
		next_restart_armed = restart_armed;
		if (bus.ss_wr && (bus.ss_addr == SS_RESTART_ADDR)) begin
			next_restart_armed = (bus.ss_wdata == SS_RESTART_VAL);
		end
		next_io_restart = bus.rsm & next_restart_armed;
		if (bus.rsm) begin
			next_restart_armed = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			smi_pend      <= 1'b0;
			nmi_pend      <= 1'b0;
			restart_armed <= 1'b0;
			io_restart    <= 1'b0;
		end else begin
			smi_pend      <= next_smi_pend;
			nmi_pend      <= next_nmi_pend;
			restart_armed <= next_restart_armed;
			io_restart    <= next_io_restart;
		end
	end

	assign bus.smi        = smi_pend & evt_ctrl[CTRL_SMI_EN];
	assign bus.nmi        = nmi_pend & ~nmi_gate_off;
	assign bus.io_restart = io_restart;

endmodule

/* File: hw/sysevt_cpu.sv */
`timescale 1ns/1ps
module sysevt_cpu
	import sysevt_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	output logic             irq_o,
	sysevt_if.cpu            bus
);

	// ***************************************************************
	// Command registers and bus pulses
	// ***************************************************************
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  pulse;
	logic        rd_pend;
	logic [7:0]  cfg_data;
	logic [2:0]  stat;
	logic [2:0]  mask;
	logic        smi_q;
	logic        nmi_q;
	logic [31:0] rdata;
	logic [15:0] next_addr;
	logic [7:0]  next_wdata;
	logic [7:0]  next_pulse;
	logic [7:0]  next_cfg_data;
	logic [2:0]  next_stat;
	logic [2:0]  next_mask;
	logic [31:0] next_rdata;
	logic [2:0]  evt;

	assign evt = {bus.io_restart, bus.nmi & ~nmi_q, bus.smi & ~smi_q};

	always_comb begin
		next_addr     = addr;
		next_wdata    = wdata;
		next_mask     = mask;
		next_pulse    = 8'h00;
		next_cfg_data = rd_pend ? bus.cfg_rdata : cfg_data;
		next_stat     = stat | evt;
		if (wr_i) begin
			unique case (addr_i)
				H_ADDR:  next_addr  = wdata_i[15:0];
				H_WDATA: next_wdata = wdata_i[7:0];
				H_CMD:   next_pulse = wdata_i[7:0];
				// Write one to clear; a new event in the same cycle still sets.
				H_STAT:  next_stat  = (stat & ~wdata_i[2:0]) | evt;
				H_MASK:  next_mask  = wdata_i[2:0];
				default: ;
			endcase
		end
		next_rdata = 32'h0000_0000;
		if (rd_i) begin
			unique case (addr_i)
				H_ADDR:     next_rdata = {16'h0000, addr};
				H_WDATA:    next_rdata = {24'h00_0000, wdata};
				H_CFG_DATA: next_rdata = {24'h00_0000, cfg_data};
				H_STAT:     next_rdata = {29'h0000_0000, stat};
				H_MASK:     next_rdata = {29'h0000_0000, mask};
				H_LEVEL:    next_rdata = {30'h0000_0000, bus.nmi, bus.smi};
				default:    next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			addr     <= 16'h0000;
			wdata    <= 8'h00;
			pulse    <= 8'h00;
			rd_pend  <= 1'b0;
			cfg_data <= 8'h00;
			stat     <= 3'h0;
			mask     <= 3'h0;
			smi_q    <= 1'b0;
			nmi_q    <= 1'b0;
			rdata    <= 32'h0000_0000;
		end else begin
			addr     <= next_addr;
			wdata    <= next_wdata;
			pulse    <= next_pulse;
			rd_pend  <= pulse[PB_CFG_RD];
			cfg_data <= next_cfg_data;
			stat     <= next_stat;
			mask     <= next_mask;
			smi_q    <= bus.smi;
			nmi_q    <= bus.nmi;
			rdata    <= next_rdata;
		end
	end

	// The port gate resets closed; the test opens it once, after enabling the first source, and leaves it open.
	// The trapped port comes from the host's own address register, never from a save-state field.
	assign bus.cfg_addr     = addr[7:0];
	assign bus.cfg_wdata    = wdata;
	assign bus.cfg_wr       = pulse[PB_CFG_WR];
	assign bus.cfg_rd       = pulse[PB_CFG_RD];
	assign bus.port70_wr    = pulse[PB_P70];
	assign bus.port70_wdata = wdata;
	assign bus.io_valid     = pulse[PB_IO];
	assign bus.io_addr      = addr;
	assign bus.ss_wr        = pulse[PB_SS_WR];
	assign bus.ss_addr      = addr;
	assign bus.ss_wdata     = wdata;
	assign bus.smi_ack      = pulse[PB_SMI_ACK];
	assign bus.nmi_ack      = pulse[PB_NMI_ACK];
	assign bus.rsm          = pulse[PB_RSM];
	assign rdata_o          = rdata;
	assign irq_o            = |(stat & mask);

endmodule

/* File: tb/sysevt_monitor.sv */
`timescale 1ns/1ps
module sysevt_monitor
	import sysevt_pkg::*;
(
	input wire logic        mclk_i,
	input wire logic        srst_i,
	input wire logic [7:0]  cfg_addr,
	input wire logic [7:0]  cfg_wdata,
	input wire logic        cfg_wr,
	input wire logic        cfg_rd,
	input wire logic [7:0]  cfg_rdata,
	input wire logic        port70_wr,
	input wire logic [7:0]  port70_wdata,
	input wire logic        io_valid,
	input wire logic [15:0] io_addr,
	input wire logic        ss_wr,
	input wire logic [15:0] ss_addr,
	input wire logic [7:0]  ss_wdata,
	input wire logic        rsm,
	input wire logic        smi_ack,
	input wire logic        nmi_ack,
	input wire logic        smi,
	input wire logic        nmi,
	input wire logic        io_restart
);
	// ***************************************************************
	// Shadow copies of the device state, rebuilt from the link.
	// ***************************************************************
	logic [7:0] ctrl;
	logic [7:0] trap_a;
	logic [7:0] trap_b;
	logic       gate;
	logic       armed;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ctrl <= 8'h00;
			trap_a <= 8'h00;
			trap_b <= 8'h00;
			gate <= NMI_GATE_RESET;
			armed <= 1'b0;
		end else begin
			if (cfg_wr && cfg_addr == OFS_EVT_CTRL) begin
				ctrl <= cfg_wdata & CTRL_WMASK;
			end
			if (cfg_wr && cfg_addr == OFS_TRAP_EN_A) begin
				trap_a <= cfg_wdata & TRAP_A_WMASK;
			end
			if (cfg_wr && cfg_addr == OFS_TRAP_EN_B) begin
				trap_b <= cfg_wdata & TRAP_B_WMASK;
			end
			if (port70_wr) begin
				gate <= port70_wdata[PORT70_GATE_BIT];
			end
			if (rsm) begin
				armed <= 1'b0;
			end else if (ss_wr && ss_addr == SS_RESTART_ADDR) begin
				armed <= (ss_wdata == SS_RESTART_VAL);
			end
		end
	end

	function automatic logic hit(input logic [15:0] a, input logic [11:0] en);
		hit = 1'b0;
		for (int i = 0; i < NUM_TRAP; i++) begin
			if (en[i] && (a & TRAP_MASK) == TRAP_BASE[i]) begin
				hit = 1'b1;
			end
		end
	endfunction

	// ***************************************************************
	// Properties.
	// ***************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	sequence s_trap_hit;
		io_valid && ctrl[CTRL_SMI_EN] && hit(io_addr, {trap_b[6:0], trap_a[4:0]});
	endsequence
	sequence s_restart_req;
		rsm && armed;
	endsequence

	property p_trap_smi; s_trap_hit |=> smi; endproperty
	a_trap_smi: assert property (p_trap_smi) else $error("trap access raised no smi");
	property p_smi_en; smi |-> ctrl[CTRL_SMI_EN]; endproperty
	a_smi_en: assert property (p_smi_en) else $error("smi high while master enable clear");
	property p_nmi_gate; nmi |-> !gate; endproperty
	a_nmi_gate: assert property (p_nmi_gate) else $error("nmi high while port gate closed");
	property p_ctrl_rb; cfg_rd && cfg_addr == OFS_EVT_CTRL |=> cfg_rdata == $past(ctrl); endproperty
	a_ctrl_rb: assert property (p_ctrl_rb) else $error("control reserved bits not zero");
	property p_ck_rsvd; cfg_rd && cfg_addr == OFS_CARD_KBD_EN |=> cfg_rdata[7:4] == 4'h0; endproperty
	a_ck_rsvd: assert property (p_ck_rsvd) else $error("card enable upper bits not zero");
	property p_trap_rb; cfg_rd && cfg_addr == OFS_TRAP_EN_A |=> cfg_rdata == $past(trap_a); endproperty
	a_trap_rb: assert property (p_trap_rb) else $error("trap enable readback wrong");
	property p_restart; s_restart_req |=> io_restart ##1 !io_restart; endproperty
	a_restart: assert property (p_restart) else $error("restart pulse missing or long");
	property p_restart_cause; io_restart |-> $past(rsm) && $past(armed); endproperty
	a_restart_cause: assert property (p_restart_cause) else $error("restart pulse without arming");
endmodule

/* File: tb/sysmgmt_event_source_logic_test.sv */
`timescale 1ns/1ps
module sysmgmt_event_source_logic_test
	import sysevt_pkg::*;
;
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic        irq_o;
	logic        cwt;
	logic [12:0] pins = 13'h01FF;
	logic [31:0] seed = 32'h28DE3B0A;
	logic [31:0] d;
	logic [15:0] a;
	logic [11:0] en;
	int          lb = 0;
	int          n_fail = 0;
	int          cmp_count = 0;
	logic [7:0]  idx [5] = '{OFS_BATAC_EN, OFS_TRAP_EN_A, OFS_TRAP_EN_B, OFS_EVT_CTRL, OFS_CARD_KBD_EN};
	logic [7:0]  msk [5] = '{8'hFF, TRAP_A_WMASK, TRAP_B_WMASK, CTRL_WMASK, CARD_KBD_WMASK};

	sysevt_if link ();
	sysevt_device sysevt_device_inst (.mclk_i(mclk_i), .srst_i(srst_i), .bus(link),
		.suspend_resume_pin_i(pins[0]), .misc_fall_pin_i(pins[4:1]), .batlow_pin_i(pins[7:5]),
		.acpresent_pin_i(pins[8]), .card_kbd_pin_i(pins[12:9]), .cache_write_through_o(cwt));
	sysevt_cpu sysevt_cpu_inst (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .bus(link));
	sysevt_monitor sysevt_monitor_inst (.mclk_i(mclk_i), .srst_i(srst_i), .cfg_addr(link.cfg_addr),
		.cfg_wdata(link.cfg_wdata), .cfg_wr(link.cfg_wr), .cfg_rd(link.cfg_rd), .cfg_rdata(link.cfg_rdata),
		.port70_wr(link.port70_wr), .port70_wdata(link.port70_wdata), .io_valid(link.io_valid),
		.io_addr(link.io_addr), .ss_wr(link.ss_wr), .ss_addr(link.ss_addr), .ss_wdata(link.ss_wdata),
		.rsm(link.rsm), .smi_ack(link.smi_ack), .nmi_ack(link.nmi_ack), .smi(link.smi), .nmi(link.nmi),
		.io_restart(link.io_restart));

	always #4 mclk_i = ~mclk_i;

	// ***************************************************************
	// Helpers for the register port and for expectations.
	// ***************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic trap_exp(input logic [15:0] x, input logic [11:0] e);
		trap_exp = 1'b0;
		for (int i = 0; i < NUM_TRAP; i++) begin
			if (e[i] && (x & 16'hFFF8) == TRAP_BASE[i]) begin
				trap_exp = 1'b1;
			end
		end
	endfunction
	task automatic results();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic hw(input logic [7:0] ad, input logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= ad;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic hr(input logic [7:0] ad, output logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= ad;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic cmd(input int b);
		hw(H_CMD, 32'h1 << b);
	endtask
	task automatic cw(input logic [7:0] i, input logic [7:0] v);
		hw(H_ADDR, {24'h0, i});
		hw(H_WDATA, {24'h0, v});
		cmd(PB_CFG_WR);
	endtask
	task automatic cr(input logic [7:0] i, output logic [31:0] v);
		hw(H_ADDR, {24'h0, i});
		cmd(PB_CFG_RD);
		repeat (3) @(posedge mclk_i);
		hr(H_CFG_DATA, v);
	endtask
	task automatic lvl(input logic e);
		repeat (6) @(posedge mclk_i);
		hr(H_LEVEL, d);
		chk("level", {31'h0, e} << lb, d);
	endtask
	task automatic ack();
		cmd(lb ? PB_NMI_ACK : PB_SMI_ACK);
		lvl(1'b0);
	endtask
	task automatic tog(input int p, input logic e);
		@(posedge mclk_i);
		pins[p] <= ~pins[p];
		lvl(e);
		if (e) begin
			ack();
		end
	endtask
	task automatic rs(input logic [7:0] v, input logic e);
		hw(H_STAT, 32'h7);
		hw(H_ADDR, {16'h0, SS_RESTART_ADDR});
		hw(H_WDATA, {24'h0, v});
		cmd(PB_SS_WR);
		cmd(PB_RSM);
		repeat (2) @(posedge mclk_i);
		hr(H_STAT, d);
		chk("restart_seen", {31'h0, e}, {31'h0, d[ST_RESTART]});
	endtask

	initial begin
		repeat (30000) @(posedge mclk_i);
		n_fail++;
		results();
	end

	// ***************************************************************
	// Main sequence.
	// ***************************************************************
	initial begin
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		foreach (idx[i]) begin
			seed = lfsr(seed);
			cr(idx[i], d);
			chk("cfg_reset", 32'h0, d);
			cw(idx[i], seed[7:0]);
			cr(idx[i], d);
			chk("cfg_readback", {24'h0, seed[7:0] & msk[i]}, d);
		end
		cw(OFS_CACHE_CFG, 8'h01);
		repeat (2) @(negedge mclk_i);
		chk("write_through", 32'h1, {31'h0, cwt});
		cw(OFS_BATAC_EN, 8'h00);
		cw(OFS_CARD_KBD_EN, 8'h00);
		cw(OFS_EVT_CTRL, 8'h01);
		for (int i = 0; i < NUM_TRAP; i++) begin
			en = 12'h1 << i;
			seed = lfsr(seed);
			cw(OFS_TRAP_EN_A, {3'h0, en[4:0]});
			cw(OFS_TRAP_EN_B, {1'b0, en[11:5]});
			a = TRAP_BASE[i] | {13'h0, seed[2:0]};
			hw(H_ADDR, {16'h0, a});
			cmd(PB_IO);
			lvl(trap_exp(a, en));
			ack();
			a = TRAP_BASE[(i + 1) % NUM_TRAP] | {13'h0, seed[5:3]};
			hw(H_ADDR, {16'h0, a});
			cmd(PB_IO);
			lvl(trap_exp(a, en));
		end
		hr(H_STAT, d);
		chk("stat_smi", 32'h1, d & 32'h1);
		hw(H_MASK, 32'h1);
		@(negedge mclk_i);
		chk("irq_on", 32'h1, {31'h0, irq_o});
		hw(H_MASK, 32'h0);
		@(negedge mclk_i);
		chk("irq_masked", 32'h0, {31'h0, irq_o});
		hw(H_MASK, 32'h1);
		hw(H_STAT, 32'h7);
		@(negedge mclk_i);
		chk("irq_cleared", 32'h0, {31'h0, irq_o});
		cw(OFS_EVT_CTRL, 8'h00);
		hw(H_ADDR, {16'h0, TRAP_BASE[NUM_TRAP-1]});
		cmd(PB_IO);
		lvl(1'b0);
		cmd(PB_SMI_ACK);
		lb = 1;
		cw(OFS_EVT_CTRL, 8'h02);
		cw(OFS_MISC_EN, 8'h04);
		tog(0, 1'b0);
		hw(H_WDATA, 32'h0);
		cmd(PB_P70);
		lvl(1'b1);
		ack();
		cw(OFS_MISC_EN, 8'h00);
		for (int k = 0; k < NUM_FALL; k++) begin
			cw(OFS_MISC_EN, 8'h04 << k);
			lvl(1'b1);
			ack();
			tog(k, 1'b0);
			tog(k, 1'b1);
			tog(k, 1'b0);
			if (k < NUM_FALL - 1) begin
				tog(k + 1, 1'b0);
			end
		end
		for (int k = 0; k < 8; k++) begin
			cw(OFS_BATAC_EN, 8'h01 << k);
			tog(5 + k / 2, !k[0]);
			tog(5 + k / 2, k[0]);
		end
		cr(OFS_BATAC_STAT, d);
		chk("batac_stat", 32'hFF, d);
		cw(OFS_BATAC_STAT, 8'hFF);
		cr(OFS_BATAC_STAT, d);
		chk("batac_clear", 32'h0, d);
		for (int i = 0; i < NUM_CK; i++) begin
			cw(OFS_CARD_KBD_EN, 8'h01 << i);
			tog(9 + (i + 1) % NUM_CK, 1'b0);
			tog(9 + (i + 1) % NUM_CK, 1'b0);
			tog(9 + i, 1'b1);
			tog(9 + i, 1'b0);
		end
		rs(SS_RESTART_VAL, 1'b1);
		rs(8'hFE, 1'b0);
		results();
	end
endmodule
